// [rtl/ssr_map.vh]
// ssr_map.vh: byte codes and field values for the shutter status reporter
// assumes: included by the design files by bare name; definitions only
`ifndef SSR_MAP_VH
`define SSR_MAP_VH

// host query codes and reply terminator
`define SSR_CMD_STATUS 8'hCC
`define SSR_CMD_TYPE 8'hFD
`define SSR_CR 8'h0D

// shutter position
`define SSR_POS_OPEN 8'hAA
`define SSR_POS_CLOSED 8'hAC

// shutter mode
`define SSR_MODE_NONE 8'hDB
`define SSR_MODE_FAST 8'hDC
`define SSR_MODE_SOFT 8'hDD
`define SSR_MODE_ND 8'hDE
`define SSR_ND_MAX 8'h90

// lead-in
`define SSR_LEAD_IN 8'hFA

// trigger input settings
`define SSR_TRIG_OFF 8'hA0
`define SSR_TRIG_HIGH 8'hA1
`define SSR_TRIG_LOW 8'hA2
`define SSR_TRIG_RISE 8'hA3
`define SSR_TRIG_FALL 8'hA4

// sync output settings
`define SSR_SYNC_OFF 8'hB0
`define SSR_SYNC_HIGH 8'hB1
`define SSR_SYNC_LOW 8'hB2

// reply fifo
`define SSR_FIFO_DEPTH 8
`define SSR_FIFO_AW 3

`endif

// [rtl/ssr_fifo.v]
// ssr_fifo.v: small synchronous fifo for reply bytes
// assumes: single clock, asynchronous active-high reset
`timescale 1ns/1ps
`include "ssr_map.vh"

module ssr_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = `SSR_FIFO_DEPTH,
	parameter AW = `SSR_FIFO_AW
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	assign in_ready = (count_r != DEPTH);
	assign out_valid = (count_r != 0);
	assign out_data = mem[rd_ptr_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage has no reset; only the pointers and the count need a defined start
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule // ssr_fifo

// [rtl/ssr_status.v]
// ssr_status.v: status and type query responder with trigger-driven shutter control
// assumes: command bytes arrive one per cycle with a valid strobe from a uart;
// reply bytes leave through a valid/ready stream; trigger input is asynchronous
`timescale 1ns/1ps
`include "ssr_map.vh"

module ssr_status #(
	parameter TYPE_LEN = 2,
	parameter [15:0] TYPE_INFO = 16'h5A01 // arbitrary identity value
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// command bytes from host
	input wire cmd_valid,
	input wire [7:0] cmd_byte,
	output wire cmd_busy,
	// reply stream to host
	output wire rsp_valid,
	input wire rsp_ready,
	output wire [7:0] rsp_data,
	// configuration
	input wire [7:0] cfg_mode,
	input wire [7:0] cfg_nd_steps,
	input wire [7:0] cfg_trig,
	input wire [7:0] cfg_sync,
	// software shutter command
	input wire sw_open_set,
	input wire sw_close_set,
	// trigger and shutter pins
	input wire trig_in,
	output wire shutter_open,
	output reg sync_out
);

	localparam ST_IDLE = 3'h0;
	localparam ST_STAT = 3'h1;
	localparam ST_TYPE = 3'h2;

	localparam IX_ECHO = 4'h0;
	localparam IX_POS = 4'h1;
	localparam IX_MODE = 4'h2;
	localparam IX_ND = 4'h3;
	localparam IX_LEAD = 4'h4;
	localparam IX_TRIG = 4'h5;
	localparam IX_SYNC = 4'h6;
	localparam IX_LAST = 4'h6;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [3:0] idx_r;
	reg [3:0] idx_nxt;
	reg [7:0] byte_nxt;
	reg push_nxt;
	reg [7:0] mode_snap_r;
	reg [7:0] nd_snap_r;
	reg [7:0] trig_snap_r;
	reg [7:0] sync_snap_r;
	reg pos_snap_r;
	reg trig_s1_r;
	reg trig_s2_r;
	reg trig_d_r;
	reg base_open_r;
	reg open_nxt;
	reg open_level;
	reg [1:0] warm_r;
	wire fifo_in_ready;
	wire rise;
	wire fall;
	wire edge_ok;

	// settings are snapshotted at query time so the reply is self-consistent
	function [7:0] clean_mode;
		input [7:0] m;
		begin
			if (m == `SSR_MODE_FAST || m == `SSR_MODE_SOFT || m == `SSR_MODE_ND) begin
				clean_mode = m;
			end else begin
				clean_mode = `SSR_MODE_NONE;
			end
		end
	endfunction

	function is_trig_mode;
		input [7:0] t;
		input [7:0] want;
		begin
			is_trig_mode = (t == want);
		end
	endfunction

	// out-of-range step counts are clamped into 1..144
	function [7:0] clamp_steps;
		input [7:0] s;
		begin
			if (s == 8'h00) begin
				clamp_steps = 8'h01;
			end else if (s > `SSR_ND_MAX) begin
				clamp_steps = `SSR_ND_MAX;
			end else begin
				clamp_steps = s;
			end
		end
	endfunction

	// unknown trigger codes are reported, and act, as disabled
	function [7:0] clean_trig;
		input [7:0] t;
		begin
			if (t >= `SSR_TRIG_OFF && t <= `SSR_TRIG_FALL) begin
				clean_trig = t;
			end else begin
				clean_trig = `SSR_TRIG_OFF;
			end
		end
	endfunction

	function [7:0] clean_sync;
		input [7:0] y;
		begin
			if (y >= `SSR_SYNC_OFF && y <= `SSR_SYNC_LOW) begin
				clean_sync = y;
			end else begin
				clean_sync = `SSR_SYNC_OFF;
			end
		end
	endfunction

	// level seen on the sync pin for a given shutter state
	function sync_level;
		input [7:0] y;
		input open;
		begin
			case (y)
				`SSR_SYNC_HIGH: sync_level = open;
				`SSR_SYNC_LOW: sync_level = !open;
				default: sync_level = 1'b0;
			endcase
		end
	endfunction

	function [7:0] pos_code;
		input open;
		begin
			pos_code = open ? `SSR_POS_OPEN : `SSR_POS_CLOSED;
		end
	endfunction

	// the microstep byte is skipped unless the mode is neutral density
	function [3:0] stat_next;
		input [3:0] ix;
		input [7:0] mode;
		begin
			if (ix == IX_MODE && mode != `SSR_MODE_ND) begin
				stat_next = IX_LEAD;
			end else begin
				stat_next = ix + 4'h1;
			end
		end
	endfunction

	function [7:0] type_byte;
		input [3:0] ix;
		begin
			if (ix < TYPE_LEN) begin
				type_byte = TYPE_INFO[8*(TYPE_LEN-1-ix) +: 8];
			end else begin
				type_byte = `SSR_CR;
			end
		end
	endfunction

	// trigger synchroniser; the first stage is never looked at, edges compare the second stage with the third
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_d_r <= 1'b0;
		end else begin
			trig_s1_r <= trig_in;
			trig_s2_r <= trig_s1_r;
			trig_d_r <= trig_s2_r;
		end
	end

	// edges are ignored until the synchroniser holds real pin samples, so a pin
	// that is already high at reset does not look like a rising edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			warm_r <= 2'h0;
		end else if (warm_r != 2'h3) begin
			warm_r <= warm_r + 2'h1;
		end
	end

	assign edge_ok = (warm_r == 2'h3);
	assign rise = edge_ok && trig_s2_r && !trig_d_r;
	assign fall = edge_ok && !trig_s2_r && trig_d_r;

	// stored shutter state: software commands and edge toggles
	always @* begin
		open_nxt = base_open_r;
		if (sw_open_set) begin
			open_nxt = 1'b1;
		end else if (sw_close_set) begin
			open_nxt = 1'b0;
		end
		if (is_trig_mode(cfg_trig, `SSR_TRIG_RISE) && rise) begin
			open_nxt = !base_open_r;
		end else if (is_trig_mode(cfg_trig, `SSR_TRIG_FALL) && fall) begin
			open_nxt = !base_open_r;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			base_open_r <= 1'b0;
		end else begin
			base_open_r <= open_nxt;
		end
	end

	// level modes override the stored state; 160 and unknown codes leave it alone
	always @* begin
		case (cfg_trig)
			`SSR_TRIG_HIGH: open_level = trig_s2_r;
			`SSR_TRIG_LOW: open_level = trig_s2_r;
			default: open_level = base_open_r;
		endcase
	end

	assign shutter_open = open_level;

	// sync output follows the shutter in the selected polarity
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_out <= 1'b0;
		end else begin
			sync_out <= sync_level(cfg_sync, shutter_open);
		end
	end

	// reply sequencer: one byte pushed per accepted fifo slot
	assign cmd_busy = (state_r != ST_IDLE);

	always @* begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		byte_nxt = 8'h00;
		push_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				idx_nxt = 4'h0;
				if (cmd_valid && cmd_byte == `SSR_CMD_STATUS) begin
					state_nxt = ST_STAT;
				end else if (cmd_valid && cmd_byte == `SSR_CMD_TYPE) begin
					state_nxt = ST_TYPE;
				end
			end
			ST_STAT: begin
				push_nxt = 1'b1;
				case (idx_r)
					IX_ECHO: byte_nxt = `SSR_CMD_STATUS;
					IX_POS: byte_nxt = pos_code(pos_snap_r);
					IX_MODE: byte_nxt = mode_snap_r;
					IX_ND: byte_nxt = nd_snap_r;
					IX_LEAD: byte_nxt = `SSR_LEAD_IN;
					IX_TRIG: byte_nxt = trig_snap_r;
					IX_SYNC: byte_nxt = sync_snap_r;
					default: byte_nxt = 8'h00;
				endcase
				if (fifo_in_ready) begin
					if (idx_r == IX_LAST) begin
						state_nxt = ST_IDLE;
					end else begin
						idx_nxt = stat_next(idx_r, mode_snap_r);
					end
				end
			end
			ST_TYPE: begin
				push_nxt = 1'b1;
				byte_nxt = type_byte(idx_r);
				if (fifo_in_ready) begin
					if (idx_r == TYPE_LEN) begin
						state_nxt = ST_IDLE;
					end else begin
						idx_nxt = idx_r + 4'h1;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			idx_r <= 4'h0;
			mode_snap_r <= `SSR_MODE_NONE;
			nd_snap_r <= 8'h01;
			trig_snap_r <= `SSR_TRIG_OFF;
			sync_snap_r <= `SSR_SYNC_OFF;
			pos_snap_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			if (state_r == ST_IDLE && cmd_valid) begin
				mode_snap_r <= clean_mode(cfg_mode);
				nd_snap_r <= clamp_steps(cfg_nd_steps);
				trig_snap_r <= clean_trig(cfg_trig);
				sync_snap_r <= clean_sync(cfg_sync);
				pos_snap_r <= shutter_open;
			end
		end
	end

	// the fifo decouples reply generation from a slow serial transmitter
	ssr_fifo #(
		.WIDTH(8),
		.DEPTH(`SSR_FIFO_DEPTH),
		.AW(`SSR_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push_nxt),
		.in_ready(fifo_in_ready),
		.in_data(byte_nxt),
		.out_valid(rsp_valid),
		.out_ready(rsp_ready),
		.out_data(rsp_data)
	);

endmodule // ssr_status

// [testbench/ssr_host.sv]
// ssr_host.sv: host model that reads reply bytes and can pause
// assumes: fed by the ssr_status reply stream; stall comes from the bench
`timescale 1ns/1ps
module ssr_host(
	input logic clk, rst, rsp_valid, stall,
	input logic [7:0] rsp_data,
	output logic rsp_ready
);
	logic [7:0] q[$];
	// a slow host just stops reading, so replies must wait in the fifo
	assign rsp_ready = !stall;
	always @(posedge clk)
		if (!rst && rsp_valid && rsp_ready) q.push_back(rsp_data);
endmodule // ssr_host

// [testbench/ssr_status_checker.sv]
// ssr_status_checker.sv: port checks for the status reporter
// assumes: bound to ssr_status; one clock, async high reset
`timescale 1ns/1ps
`include "ssr_map.vh"
module ssr_status_checker(
	input logic clk, rst, cmd_valid, cmd_busy, rsp_valid, rsp_ready,
	input logic [7:0] cmd_byte, rsp_data, cfg_mode, cfg_nd_steps, cfg_trig, cfg_sync,
	input logic sw_open_set, sw_close_set, trig_in, shutter_open, sync_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire q = !sw_open_set && !sw_close_set;
	wire take = cmd_valid && !cmd_busy;
	a_echo_first: assert property (take && cmd_byte == `SSR_CMD_STATUS && !rsp_valid
		|-> ##2 rsp_valid && rsp_data == `SSR_CMD_STATUS) else $error("no echo");
	a_query_busy: assert property (take && cmd_byte == `SSR_CMD_TYPE |=> cmd_busy)
		else $error("type not taken");
	a_trig_off: assert property (cfg_trig == `SSR_TRIG_OFF && $stable(cfg_trig) && q
		|=> cfg_trig != `SSR_TRIG_OFF || $stable(shutter_open)) else $error("off moved");
	a_level_high: assert property ((cfg_trig == `SSR_TRIG_HIGH && trig_in)[*3]
		|-> shutter_open) else $error("high not open");
	a_level_low: assert property ((cfg_trig == `SSR_TRIG_LOW && !trig_in)[*3]
		|-> !shutter_open) else $error("low not closed");
	a_rise_flip: assert property (cfg_trig == `SSR_TRIG_RISE && $rose(trig_in) && q
		|-> ##[2:4] $changed(shutter_open)) else $error("rise no toggle");
	a_fall_flip: assert property (cfg_trig == `SSR_TRIG_FALL && $fell(trig_in) && q
		|-> ##[2:4] $changed(shutter_open)) else $error("fall no toggle");
	a_sync_off: assert property (cfg_sync == `SSR_SYNC_OFF |=> !sync_out)
		else $error("sync not off");
	a_sync_follow: assert property (cfg_sync == `SSR_SYNC_HIGH
		|=> sync_out == $past(shutter_open)) else $error("sync not high");
	a_sync_invert: assert property (cfg_sync == `SSR_SYNC_LOW
		|=> sync_out != $past(shutter_open)) else $error("sync not low");
	c_status: cover property (take && cmd_byte == `SSR_CMD_STATUS);
	c_full: cover property (rsp_valid && !rsp_ready && cmd_busy);
	c_open: cover property ($rose(shutter_open));
endmodule // ssr_status_checker

// [testbench/tb_top.sv]
// tb_top.sv: directed status, type, fifo and trigger tests
// assumes: rtl compiled with ssr_host and ssr_status_checker
`timescale 1ns/1ps
`include "ssr_map.vh"
module tb_top;
	localparam [15:0] TI = 16'h5A01; // arbitrary identity value
	logic clk = 0, rst = 1, cmd_valid = 0, rsp_ready, rsp_valid, cmd_busy, stall = 0;
	logic sw_open_set = 0, sw_close_set = 0, trig_in = 0, shutter_open, sync_out;
	logic [7:0] cmd_byte = 0, rsp_data, cfg_mode = 0, cfg_nd_steps = 0, cfg_trig = 0, cfg_sync = 0;
	logic [7:0] tt[9] = '{8'hA1, 8'hA1, 8'hA2, 8'hA2, 8'hA3, 8'hA3, 8'hA3, 8'hA4, 8'hA4};
	logic [8:0] tv = 9'b010101001, tx = 9'b011101001;
	int n_errors = 0, n_tests = 0;
	always #12.5 clk = ~clk;
	ssr_status #(.TYPE_LEN(2), .TYPE_INFO(TI)) i_dut(.clk, .rst, .cmd_valid, .cmd_byte,
		.cmd_busy, .rsp_valid, .rsp_ready, .rsp_data, .cfg_mode, .cfg_nd_steps, .cfg_trig,
		.cfg_sync, .sw_open_set, .sw_close_set, .trig_in, .shutter_open, .sync_out);
	ssr_host i_host(.clk, .rst, .rsp_valid, .stall, .rsp_data, .rsp_ready);
	task print_verdict;
		if (n_errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, x);
		n_tests++;
		if (s !== x) begin
			$display("[FAIL] %s expected %h seen %h", n, x, s);
			n_errors++;
		end
	endtask
	task cmd(input logic [7:0] c);
		@(negedge clk) cmd_valid = 1;
		cmd_byte = c;
		@(negedge clk) cmd_valid = 0;
		for (int k = 0; k < 40 && cmd_busy !== 0; k++) @(negedge clk);
	endtask
	task drain(input logic [7:0] e[$]);
		for (int k = 0; k < 60 && (rsp_valid !== 0 || cmd_busy !== 0); k++) @(negedge clk);
		chk("count", 8'(i_host.q.size()), 8'(e.size()));
		foreach (e[i]) chk("byte", i_host.q[i], e[i]);
		i_host.q.delete();
	endtask
	task stat(input logic [7:0] m, s, t, y, input logic o);
		logic [7:0] e[$];
		cfg_mode = m;
		cfg_nd_steps = s;
		cfg_trig = t;
		cfg_sync = y;
		e = {`SSR_CMD_STATUS, o ? `SSR_POS_OPEN : `SSR_POS_CLOSED, m};
		if (m == `SSR_MODE_ND) e.push_back(s);
		e = {e, `SSR_LEAD_IN, t, y};
		cmd(`SSR_CMD_STATUS);
		drain(e);
	endtask
	task trg(input logic [7:0] t, input logic v, x);
		cfg_trig = t;
		trig_in = v;
		// margin over the synchroniser and edge detect delay
		repeat (6) @(negedge clk);
		chk("shutter", shutter_open, x);
		chk("sync", sync_out, cfg_sync == 8'hB1 ? x : cfg_sync == 8'hB2 ? !x : 1'b0);
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst = 0;
		stat(`SSR_MODE_NONE, 1, `SSR_TRIG_OFF, `SSR_SYNC_OFF, 0);
		stat(`SSR_MODE_FAST, 1, `SSR_TRIG_HIGH, `SSR_SYNC_HIGH, 0);
		stat(`SSR_MODE_SOFT, 1, `SSR_TRIG_LOW, `SSR_SYNC_LOW, 0);
		stat(`SSR_MODE_ND, `SSR_ND_MAX, `SSR_TRIG_RISE, `SSR_SYNC_OFF, 0);
		@(negedge clk) sw_open_set = 1;
		@(negedge clk) sw_open_set = 0;
		stat(`SSR_MODE_ND, 1, `SSR_TRIG_OFF, `SSR_SYNC_HIGH, 1);
		// host stops reading: ten bytes cannot fit eight places
		stall = 1;
		cmd(`SSR_CMD_STATUS);
		cmd(`SSR_CMD_TYPE);
		cmd(`SSR_CMD_STATUS);
		chk("full", {6'h0, rsp_valid, cmd_busy}, 8'h03);
		stall = 0;
		drain({8'hCC, 8'hAA, 8'hDE, 8'h01, 8'hFA, 8'hA0, 8'hB1, TI[15:8], TI[7:0], `SSR_CR});
		stat(`SSR_MODE_FAST, 1, `SSR_TRIG_FALL, `SSR_SYNC_LOW, 1);
		cfg_sync = `SSR_SYNC_HIGH;
		for (int i = 0; i < 9; i++) begin
			if (i == 4) begin
				@(negedge clk) sw_close_set = 1;
				@(negedge clk) sw_close_set = 0;
				cfg_sync = `SSR_SYNC_LOW;
			end
			trg(tt[i], tv[i], tx[i]);
		end
		cfg_sync = `SSR_SYNC_OFF;
		trg(`SSR_TRIG_OFF, 1, 0);
		// unknown codes report as disabled or no shutter; step counts are clamped
		cfg_mode = 8'h05;
		cfg_trig = 8'hA7;
		cfg_sync = 8'hB5;
		cmd(`SSR_CMD_STATUS);
		drain({8'hCC, 8'hAC, 8'hDB, 8'hFA, 8'hA0, 8'hB0});
		cfg_mode = `SSR_MODE_ND;
		cfg_nd_steps = 8'h00;
		cmd(`SSR_CMD_STATUS);
		drain({8'hCC, 8'hAC, 8'hDE, 8'h01, 8'hFA, 8'hA0, 8'hB0});
		cfg_nd_steps = 8'hC8;
		cmd(`SSR_CMD_STATUS);
		drain({8'hCC, 8'hAC, 8'hDE, 8'h90, 8'hFA, 8'hA0, 8'hB0});
		print_verdict;
	end
	initial begin
		#100000;
		n_errors++;
		print_verdict;
	end
endmodule // tb_top
bind ssr_status ssr_status_checker i_chk(.clk, .rst, .cmd_valid, .cmd_busy, .rsp_valid,
	.rsp_ready, .cmd_byte, .rsp_data, .cfg_mode, .cfg_nd_steps, .cfg_trig, .cfg_sync,
	.sw_open_set, .sw_close_set, .trig_in, .shutter_open, .sync_out);
